// *** pwt_pkg.sv ***
// Package with constants and types for the watchdog timer
// Overview of operation
// [RQ1] On expiry without a kick the block requests shutdown and restores its config to reset values.
// [RQ2] The host starts the watchdog by setting the enable field, and timing begins when it is set.
// [RQ3] A two-bit period select chooses one of four periods from 16 to 128 seconds.
// [RQ4] After reset the period select holds the 128 second setting.
// [RQ5] While enabled the host must kick before each period ends, and every kick restarts the count.
// [RQ6] The lock option is a read-only factory value that no write can change.
// [RQ7] With lock clear, host writes may set or clear the enable, which resets to its factory default.
// [RQ8] With lock set and enable default zero, a write of one is taken and a write of zero ignored.
// [RQ9] With lock set and enable default one, the watchdog stays enabled whatever happens.
// [RQ10] Expiry with the expiry action at one sets the reset cause flag and requests a cold reset.
// [RQ11] Expiry with the expiry action at zero sets the off cause flag and requests a power-off.
// [RQ12] Codes zero to three give 16, 32, 64 and 128 seconds, and the kick bit reads back as zero.
package pwt_pkg;
  localparam longint unsigned CLK_HZ          = 64'd40000000;
  localparam int              CNT_W           = 33;
  localparam longint unsigned WD_PERIOD_S0    = 64'd16;
  localparam longint unsigned WD_PERIOD_S1    = 64'd32;
  localparam longint unsigned WD_PERIOD_S2    = 64'd64;
  localparam longint unsigned WD_PERIOD_S3    = 64'd128;
  localparam logic [32:0]     WD_CYC0         = 33'(WD_PERIOD_S0 * CLK_HZ);
  localparam logic [32:0]     WD_CYC1         = 33'(WD_PERIOD_S1 * CLK_HZ);
  localparam logic [32:0]     WD_CYC2         = 33'(WD_PERIOD_S2 * CLK_HZ);
  localparam logic [32:0]     WD_CYC3         = 33'(WD_PERIOD_S3 * CLK_HZ);
  localparam logic [1:0]      PER_16S         = 2'h0;
  localparam logic [1:0]      PER_32S         = 2'h1;
  localparam logic [1:0]      PER_64S         = 2'h2;
  localparam logic [1:0]      PER_128S        = 2'h3;
  localparam logic [1:0]      PER_RST         = PER_128S;
  localparam logic            ACTION_RST      = 1'h0;
  localparam logic            ACTION_COLD_RST = 1'h1;
  localparam logic            ACTION_OFF      = 1'h0;

  typedef struct packed {
    logic       enable;
    logic [1:0] period_sel;
    logic       expiry_action;
  } pwt_cfg_t;

  typedef struct packed {
    logic       enable;
    logic [1:0] period_sel;
    logic       expiry_action;
    logic       kick;
  } pwt_wr_t;

  typedef struct packed {
    logic reset_cause;
    logic off_cause;
  } pwt_flags_t;
endpackage

// *** pwt_counter.sv ***
// Period counter with restart and expiry detect
`timescale 1ns/1ps
`default_nettype none
module pwt_counter (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic                      run,
  input  wire logic                      restart,
  input  wire logic [pwt_pkg::CNT_W-1:0] limit,
  output logic                           expire,
  output logic      [pwt_pkg::CNT_W-1:0] count
);
  logic [pwt_pkg::CNT_W-1:0] cnt_q;
  logic [pwt_pkg::CNT_W-1:0] cnt_d;

  always_comb begin
    expire = run && !restart && (cnt_q >= limit - 33'h1);
    if (!run || restart || expire) begin // see [RQ2] see [RQ5]
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + 33'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign count = cnt_q;

  AST_COUNT_BOUND: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ5]
    cnt_q < limit || !run)
    else $error("Count ran past the period limit");
endmodule
`default_nettype wire

// *** pmic_watchdog_timer.sv ***
// Watchdog timer with factory lock options and expiry requests
`timescale 1ns/1ps
`default_nettype none
module pmic_watchdog_timer #(
  parameter logic [32:0] PERIOD0_CYC = pwt_pkg::WD_CYC0,
  parameter logic [32:0] PERIOD1_CYC = pwt_pkg::WD_CYC1,
  parameter logic [32:0] PERIOD2_CYC = pwt_pkg::WD_CYC2,
  parameter logic [32:0] PERIOD3_CYC = pwt_pkg::WD_CYC3
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               wd_lock_option,
  input  wire logic               wd_enable_default,
  input  wire logic               cfg_wr_valid,
  input  wire pwt_pkg::pwt_wr_t   cfg_wr,
  input  wire pwt_pkg::pwt_flags_t flags_clr,
  output pwt_pkg::pwt_cfg_t       watchdog_config,
  output logic                    wd_kick,
  output logic                    wd_lock_status,
  output pwt_pkg::pwt_flags_t     event_cause_flags,
  output logic                    req_cold_reset,
  output logic                    req_power_off,
  output logic                    cfg_restore
);
  pwt_pkg::pwt_cfg_t   cfg_q;
  pwt_pkg::pwt_cfg_t   cfg_d;
  pwt_pkg::pwt_flags_t flags_q;
  pwt_pkg::pwt_flags_t flags_d;
  logic                loaded_q;
  logic                loaded_d;
  logic                lock_q;
  logic                lock_d;
  logic                endef_q;
  logic                endef_d;
  logic                cold_q;
  logic                cold_d;
  logic                off_q;
  logic                off_d;
  logic                restore_q;
  logic                restore_d;
  logic                expire;
  logic                restart;
  logic [32:0]         limit;
  logic [32:0]         count;

  // Period select to cycle limit
  always_comb begin
    unique case (cfg_q.period_sel) // see [RQ3] see [RQ12]
      pwt_pkg::PER_16S: limit = PERIOD0_CYC;
      pwt_pkg::PER_32S: limit = PERIOD1_CYC;
      pwt_pkg::PER_64S: limit = PERIOD2_CYC;
      pwt_pkg::PER_128S: limit = PERIOD3_CYC;
    endcase
  end

  // Kick restarts the shared counter
  assign restart = cfg_wr_valid && cfg_wr.kick; // see [RQ5]

  pwt_counter u_counter (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (cfg_q.enable && loaded_q),
    .restart (restart),
    .limit   (limit),
    .expire  (expire),
    .count   (count)
  );

  // Strap load, expiry restore and host writes
  always_comb begin
    loaded_d  = 1'b1;
    lock_d    = lock_q;
    endef_d   = endef_q;
    cfg_d     = cfg_q;
    cold_d    = 1'b0;
    off_d     = 1'b0;
    restore_d = 1'b0;
    flags_d   = flags_q & ~flags_clr;
    if (!loaded_q) begin
      lock_d              = wd_lock_option; // see [RQ6]
      endef_d             = wd_enable_default;
      cfg_d.enable        = wd_enable_default; // see [RQ7]
      cfg_d.period_sel    = pwt_pkg::PER_RST; // see [RQ4]
      cfg_d.expiry_action = pwt_pkg::ACTION_RST;
    end else if (expire) begin
      cfg_d.enable        = endef_q; // see [RQ1]
      cfg_d.period_sel    = pwt_pkg::PER_RST;
      cfg_d.expiry_action = pwt_pkg::ACTION_RST;
      restore_d           = 1'b1;
      if (cfg_q.expiry_action == pwt_pkg::ACTION_COLD_RST) begin
        cold_d              = 1'b1; // see [RQ10]
        flags_d.reset_cause = 1'b1;
      end else begin
        off_d             = 1'b1; // see [RQ11]
        flags_d.off_cause = 1'b1;
      end
    end else if (cfg_wr_valid) begin
      cfg_d.period_sel    = cfg_wr.period_sel;
      cfg_d.expiry_action = cfg_wr.expiry_action;
      if (!lock_q || cfg_wr.enable) begin
        cfg_d.enable = cfg_wr.enable; // see [RQ2] see [RQ7] see [RQ8]
      end
    end
    if (loaded_q && lock_q && endef_q) begin
      cfg_d.enable = 1'b1; // see [RQ9]
    end
  end

  // Config, flag and request registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      loaded_q  <= 1'b0;
      lock_q    <= 1'b0;
      endef_q   <= 1'b0;
      cfg_q     <= '{enable: 1'b0, period_sel: pwt_pkg::PER_RST,
                     expiry_action: pwt_pkg::ACTION_RST};
      flags_q   <= '0;
      cold_q    <= 1'b0;
      off_q     <= 1'b0;
      restore_q <= 1'b0;
    end else begin
      loaded_q  <= loaded_d;
      lock_q    <= lock_d;
      endef_q   <= endef_d;
      cfg_q     <= cfg_d;
      flags_q   <= flags_d;
      cold_q    <= cold_d;
      off_q     <= off_d;
      restore_q <= restore_d;
    end
  end

  // Outputs
  assign watchdog_config   = cfg_q;
  assign wd_kick           = 1'b0; // see [RQ12]
  assign wd_lock_status    = lock_q; // see [RQ6]
  assign event_cause_flags = flags_q;
  assign req_cold_reset    = cold_q;
  assign req_power_off     = off_q;
  assign cfg_restore       = restore_q;

  // Rule checks
  AST_EXPIRE_RESTORE: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ1]
    expire |=> cfg_restore && cfg_q.period_sel == pwt_pkg::PER_RST && (cold_q ^ off_q))
    else $error("Expiry did not restore config and request shutdown");
  AST_DISABLED_IDLE: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ2]
    !cfg_q.enable |=> count == 33'h0)
    else $error("Count moved while disabled");
  AST_PERIOD_MAP: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ3]
    cfg_q.period_sel == pwt_pkg::PER_16S |-> limit == PERIOD0_CYC)
    else $error("Shortest period select gave wrong limit");
  AST_PERIOD_DEFAULT: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ4]
    $rose(loaded_q) |-> cfg_q.period_sel == pwt_pkg::PER_128S)
    else $error("Period select not at longest after reset");
  AST_KICK_RESTART: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ5]
    restart |=> count == 33'h0)
    else $error("Kick did not restart the count");
  AST_LOCK_STABLE: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ6]
    loaded_q |=> $stable(wd_lock_status))
    else $error("Lock option changed after load");
  AST_FREE_ENABLE: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ7]
    loaded_q && !lock_q && cfg_wr_valid && !expire |=> cfg_q.enable == $past(cfg_wr.enable))
    else $error("Unlocked enable write not taken");
  AST_LOCK_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ8]
    loaded_q && lock_q && cfg_q.enable && !expire |=> cfg_q.enable)
    else $error("Locked enable was cleared by a write");
  AST_PERMANENT: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ9]
    $past(loaded_q) && lock_q && endef_q |-> cfg_q.enable)
    else $error("Permanently enabled watchdog was disabled");
  AST_COLD_CAUSE: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ10]
    expire && cfg_q.expiry_action |=> req_cold_reset && !req_power_off && flags_q.reset_cause)
    else $error("Cold reset expiry not flagged");
  AST_OFF_CAUSE: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ11]
    expire && !cfg_q.expiry_action |=> req_power_off && !req_cold_reset && flags_q.off_cause)
    else $error("Power-off expiry not flagged");
  AST_RESTORE_PAIR: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ1]
    cfg_restore |-> req_cold_reset || req_power_off)
    else $error("Config restored without a shutdown request");
  AST_RESTORE_ACTION: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ1]
    expire |=> cfg_q.expiry_action == pwt_pkg::ACTION_RST)
    else $error("Expiry action not restored after expiry");
  AST_REQ_PULSE: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ1]
    req_cold_reset || req_power_off |=> !req_cold_reset && !req_power_off)
    else $error("Shutdown request lasted more than one cycle");
  AST_ENABLE_START: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ2]
    $rose(cfg_q.enable) && !restart |=> count == 33'h1)
    else $error("Timing did not start when enable was set");
  AST_NO_REQ_IDLE: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ2]
    !cfg_q.enable |=> !req_cold_reset && !req_power_off)
    else $error("Shutdown requested while disabled");
  AST_PERIOD_WRITE: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ3]
    loaded_q && cfg_wr_valid && !expire |=> cfg_q.period_sel == $past(cfg_wr.period_sel))
    else $error("Period select write not taken");
  AST_PERIOD_LONGEST: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ12]
    cfg_q.period_sel == pwt_pkg::PER_128S |-> limit == PERIOD3_CYC)
    else $error("Longest period select gave wrong limit");
  AST_LOCK_SET_ONE: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ8]
    loaded_q && lock_q && cfg_wr_valid && cfg_wr.enable && !expire |=> cfg_q.enable)
    else $error("Locked enable did not accept a write of one");
  AST_RST_STICKY: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ10]
    flags_q.reset_cause && !flags_clr.reset_cause |=> flags_q.reset_cause)
    else $error("Reset cause flag dropped without a clear");
  AST_OFF_STICKY: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ11]
    flags_q.off_cause && !flags_clr.off_cause |=> flags_q.off_cause)
    else $error("Off cause flag dropped without a clear");
  AST_RST_CLEAR: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ10]
    flags_clr.reset_cause && !(expire && cfg_q.expiry_action) |=> !flags_q.reset_cause)
    else $error("Reset cause flag not cleared");
  AST_OFF_CLEAR: assert property (@(posedge clk) disable iff (sys_rst) // see [RQ11]
    flags_clr.off_cause && !(expire && !cfg_q.expiry_action) |=> !flags_q.off_cause)
    else $error("Off cause flag not cleared");

  // Main scenarios
  COV_COLD: cover property (@(posedge clk) disable iff (sys_rst) req_cold_reset);
  COV_OFF: cover property (@(posedge clk) disable iff (sys_rst) req_power_off);
  COV_KICK: cover property (@(posedge clk) disable iff (sys_rst) cfg_q.enable && restart);
  COV_LOCK_IGNORE: cover property (@(posedge clk) disable iff (sys_rst)
    lock_q && cfg_q.enable && cfg_wr_valid && !cfg_wr.enable);
  COV_PERMANENT: cover property (@(posedge clk) disable iff (sys_rst)
    lock_q && endef_q && expire);
endmodule
`default_nettype wire

// *** pwt_host.sv ***
// Host model issuing configuration writes
`timescale 1ns/1ps
`default_nettype none
module pwt_host (
  input  wire logic        clk,
  output logic             cfg_wr_valid,
  output pwt_pkg::pwt_wr_t cfg_wr
);
  initial begin
    cfg_wr_valid = 1'b0;
    cfg_wr       = '0;
  end
  // One strobe per write, fields inverted on release
  task automatic wr(input logic en, input logic [1:0] per, input logic act, input logic kick);
    @(negedge clk);
    cfg_wr_valid = 1'b1;
    cfg_wr       = {en, per, act, kick};
    @(negedge clk);
    cfg_wr_valid = 1'b0;
    cfg_wr       = ~cfg_wr;
  endtask
endmodule
`default_nettype wire

// *** test_pmic_watchdog_timer.sv ***
// Self-checking bench for the watchdog timer
`timescale 1ns/1ps
`default_nettype none
module test_pmic_watchdog_timer;
  logic                clk;
  logic                sys_rst;
  logic                lock_r;
  logic                def_r;
  logic                any_req;
  logic                cfg_wr_valid;
  logic                kick;
  logic                lock_s;
  logic                cold;
  logic                off;
  logic                restore;
  pwt_pkg::pwt_wr_t    cfg_wr;
  pwt_pkg::pwt_flags_t flags_clr;
  pwt_pkg::pwt_flags_t flg;
  pwt_pkg::pwt_cfg_t   cfg;
  int                  error_cnt;
  int                  cmp_count;
  int                  cyc;
  int                  n;

  pwt_host host_u (.clk(clk), .cfg_wr_valid(cfg_wr_valid), .cfg_wr(cfg_wr));
  pmic_watchdog_timer #(.PERIOD0_CYC(33'h14), .PERIOD1_CYC(33'h28),
    .PERIOD2_CYC(33'h50), .PERIOD3_CYC(33'ha0)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .wd_lock_option(lock_r), .wd_enable_default(def_r),
    .cfg_wr_valid(cfg_wr_valid), .cfg_wr(cfg_wr), .flags_clr(flags_clr),
    .watchdog_config(cfg), .wd_kick(kick), .wd_lock_status(lock_s),
    .event_cause_flags(flg), .req_cold_reset(cold), .req_power_off(off),
    .cfg_restore(restore));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(negedge clk) begin
    cyc = cyc + 1;
    if (cold | off) any_req = 1'b1;
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic do_reset(input logic l, input logic d);
    @(negedge clk);
    sys_rst = 1'b1;
    lock_r  = l;
    def_r   = d;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // Wait for expiry, then check pulses, flags and restored config
  task automatic expire(input int lim, input logic act);
    n = 0;
    while (!(cold | off) && n < 400) begin
      @(negedge clk);
      n = n + 1;
    end
    chk(8'(n == lim), 8'h1);
    chk({4'h0, cold, off, restore, 1'b0}, {4'h0, act, !act, 2'b10});
    chk(8'(flg), {6'h0, act, !act});
    chk({4'h0, cfg}, {4'h0, def_r, 2'h3, 1'b0});
    flags_clr = 2'b11;
    @(negedge clk);
    flags_clr = 2'b00;
    chk(8'(flg), 8'h0);
  endtask

  initial begin
    sys_rst   = 1'b1;
    lock_r    = 1'b0;
    def_r     = 1'b0;
    flags_clr = 2'b00;
    any_req   = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    cyc       = 0;
    do_reset(1'b0, 1'b0);
    chk({4'h0, cfg}, 8'h06);
    chk({6'h0, kick, lock_s}, 8'h0);
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      host_u.wr(1'b1, 2'(c), c[0], 1'b0);
      chk({4'h0, cfg}, {4'h0, 1'b1, 2'(c), c[0]});
      expire(20 << c, c[0]);
    end
    $display("test periods done");
    host_u.wr(1'b1, 2'h0, 1'b0, 1'b0);
    any_req = 1'b0;
    repeat (6) begin
      repeat (12) @(negedge clk);
      host_u.wr(1'b1, 2'h0, 1'b0, 1'b1);
      chk({7'h0, kick}, 8'h0);
    end
    chk({7'h0, any_req}, 8'h0);
    host_u.wr(1'b0, 2'h0, 1'b0, 1'b0);
    repeat (40) @(negedge clk);
    chk({7'h0, any_req}, 8'h0);
    $display("test kick done");
    do_reset(1'b1, 1'b0);
    chk({7'h0, lock_s}, 8'h1);
    host_u.wr(1'b1, 2'h3, 1'b0, 1'b0);
    host_u.wr(1'b0, 2'h3, 1'b0, 1'b0);
    chk({4'h0, cfg}, 8'h0e);
    do_reset(1'b1, 1'b0);
    chk({7'h0, cfg.enable}, 8'h0);
    $display("test lock done");
    do_reset(1'b1, 1'b1);
    host_u.wr(1'b0, 2'h0, 1'b1, 1'b1);
    chk({4'h0, cfg}, 8'h09);
    expire(20, 1'b1);
    $display("test locked on done");
    print_verdict();
  end
endmodule
`default_nettype wire
